// ==== vts_defines.vh ====
// Register map, field layout, reset values and codes of the edge shaper
`ifndef VTS_DEFINES_VH
`define VTS_DEFINES_VH
// Register indices; byte address is four times the index
`define VTS_IDX_SLOW_RESID 10'h04C
`define VTS_IDX_SLOW_TYPE 10'h04D
`define VTS_IDX_SLOW_STYLE 10'h04E
`define VTS_IDX_SLOW_LEN 10'h04F
`define VTS_IDX_FAST_RESID 10'h050
`define VTS_IDX_FAST_TYPE 10'h051
`define VTS_IDX_FAST_STYLE 10'h052
`define VTS_IDX_FAST_LEN 10'h053
`define VTS_IDX_CTRL 10'h060
`define VTS_IDX_STAT 10'h061
// Reset values
`define VTS_RST_RESID 8'hE0
`define VTS_RST_TYPE 8'h11
`define VTS_RST_STYLE 8'h00
`define VTS_RST_LEN 8'h08
`define VTS_RST_CTRL 8'h01
// Field positions
`define VTS_TYPE_FALL 7:4
`define VTS_TYPE_RISE 3:0
`define VTS_STYLE_FALL 6:4
`define VTS_STYLE_RISE 2:0
`define VTS_STYLE_MASK 8'h77
`define VTS_LEN_DOUBLE 7
`define VTS_LEN_COUNT 4:0
`define VTS_LEN_MASK 8'h9F
`define VTS_CTRL_ENABLE 0
`define VTS_CTRL_FAST 1
`define VTS_CTRL_MASK 8'h03
`define VTS_BYTE 7:0
`define VTS_ADDR_IDX 11:2
// Edge shaping codes
`define VTS_CODE_LIN1 4'h1
`define VTS_CODE_LIN2 4'h2
`define VTS_CODE_LIN3 4'h3
`define VTS_CODE_LUT 4'h4
`define VTS_CODE_LUT_CORR 4'h5
`define VTS_CODE_LUT_ADAPT 4'h6
// Amplitude levels
`define VTS_AMP_FULL 8'hFF
`define VTS_AMP_ZERO 8'h00
`endif

// ==== vts_curve.v ====
// Shape function: maps edge progress to a shaped fraction of the swing
`timescale 1ns/1ps
module vts_curve (
	input wire [3:0] shapeCode,
	input wire [2:0] styleSel,
	input wire [7:0] progress,
	input wire [7:0] supplyLevel,
	output reg [7:0] shapedLevel
);
`include "vts_defines.vh"

	reg [7:0] knee; // Corner level of segmented ramps
	reg [7:0] inv; // Remaining progress
	reg [15:0] prod; // Scratch product
	reg [7:0] tableVal; // Table entry before supply scaling
	reg [15:0] scaled; // Table entry times supply

	// Segment arithmetic uses multiplies and bit slices, so no divider is needed here
	always @* begin
		knee = {styleSel, 5'h10};
		inv = 8'hFF - progress;
		prod = 16'h0000;
		tableVal = `VTS_AMP_ZERO;
		scaled = 16'h0000;
		shapedLevel = progress;
		// Four table shapes, chosen by the low two bits of the style
		case (styleSel[1:0])
			2'h0: tableVal = progress;
			2'h1: begin
				prod = progress * progress;
				tableVal = prod[15:8];
			end
			2'h2: begin
				prod = inv * inv;
				tableVal = 8'hFF - prod[15:8];
			end
			default: begin
				if (progress < 8'h80) begin
					prod = progress * progress;
					tableVal = prod[14:7];
				end else begin
					prod = inv * inv;
					tableVal = 8'hFF - prod[14:7];
				end
			end
		endcase
		scaled = tableVal * supplyLevel;
		case (shapeCode)
			`VTS_CODE_LIN1: shapedLevel = progress;
			// Two segments meeting at mid progress, knee set by style
			`VTS_CODE_LIN2: begin
				if (progress < 8'h80) begin
					prod = progress * knee;
					shapedLevel = prod[14:7];
				end else begin
					prod = (progress - 8'h80) * (8'hFF - knee);
					shapedLevel = knee + prod[14:7];
				end
			end
			// Soft start and end, steep middle; style sets softness
			`VTS_CODE_LIN3: begin
				knee = {2'h0, styleSel, 3'h0};
				if (progress < 8'h40) begin
					prod = progress * knee;
					shapedLevel = prod[13:6];
				end else if (progress < 8'hC0) begin
					prod = (progress - 8'h40) * (8'hFF - knee - knee);
					shapedLevel = knee + prod[14:7];
				end else begin
					prod = (progress - 8'hC0) * knee;
					shapedLevel = 8'hFF - knee + prod[13:6];
				end
			end
			`VTS_CODE_LUT: shapedLevel = tableVal;
			`VTS_CODE_LUT_CORR: shapedLevel = scaled[15:8];
			`VTS_CODE_LUT_ADAPT: shapedLevel = scaled[15:8];
			// Reserved codes fall back to a plain linear ramp
			default: shapedLevel = progress;
		endcase
	end
endmodule

// ==== vts_shaper.v ====
// Transmit carrier edge shaper for vicinity reader mode with APB registers
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
module vts_shaper (
	input wire clock,
	input wire reset_n,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire modRequest,
	input wire carrierTick,
	input wire [7:0] amplifierSupplyVoltage,
	output reg [7:0] carrierAmplitude,
	output reg edgeBusy
);
`include "vts_defines.vh"

	// One-hot shaper states
	localparam [3:0] ST_UNMOD = 4'b0001; // Full carrier
	localparam [3:0] ST_FALL = 4'b0010; // Falling edge in progress
	localparam [3:0] ST_LOW = 4'b0100; // Held at residual level
	localparam [3:0] ST_RISE = 4'b1000; // Rising edge in progress

	// Configuration registers, one group per data rate
	reg [7:0] slowResidualLevel_q;
	reg [7:0] slowEdgeType_q;
	reg [7:0] slowEdgeStyle_q;
	reg [7:0] slowEdgeLength_q;
	reg [7:0] fastResidualLevel_q;
	reg [7:0] fastEdgeType_q;
	reg [7:0] fastEdgeStyle_q;
	reg [7:0] fastEdgeLength_q;
	reg [7:0] control_q; // Enable and rate select

	// Synchronisers for pins from outside the clock domain
	reg modSync1_q;
	reg modSync2_q;
	reg tickSync1_q;
	reg tickSync2_q;
	reg tickSync3_q; // Edge detector history, fed from second stage only
	reg [7:0] supplySync1_q;
	reg [7:0] supplySync2_q;

	// Shaper state
	reg [3:0] state_q;
	reg [3:0] state_d;
	reg [5:0] step_q; // Current transition state, counted from one
	reg [5:0] step_d;
	reg half_q; // Second carrier cycle of a doubled state
	reg half_d;
	reg group_q; // Rate group latched at the falling edge
	reg group_d;
	reg [7:0] supply_q; // Supply code latched at the falling edge
	reg [7:0] supply_d;
	reg [7:0] amp_d;

	// Decoded access and active configuration
	wire [9:0] regIdx = paddr[`VTS_ADDR_IDX];
	wire setupPhase = psel & ~penable;
	wire writeNow = psel & penable & pready & pwrite & ~pslverr & pstrb[0];
	wire [7:0] wByte = pwdata[`VTS_BYTE];
	wire tickPulse = tickSync2_q & ~tickSync3_q;
	wire enable = control_q[`VTS_CTRL_ENABLE];
	wire [7:0] residual = group_q ? fastResidualLevel_q : slowResidualLevel_q;
	wire [7:0] edgeType = group_q ? fastEdgeType_q : slowEdgeType_q;
	wire [7:0] edgeStyle = group_q ? fastEdgeStyle_q : slowEdgeStyle_q;
	wire [7:0] edgeLength = group_q ? fastEdgeLength_q : slowEdgeLength_q;
	wire falling = (state_q == ST_FALL);
	wire [3:0] shapeCode = falling ? edgeType[`VTS_TYPE_FALL] : edgeType[`VTS_TYPE_RISE];
	wire [2:0] styleSel = falling ? edgeStyle[`VTS_STYLE_FALL] : edgeStyle[`VTS_STYLE_RISE];
	wire [5:0] stateCount = {1'b0, edgeLength[`VTS_LEN_COUNT]};
	wire doubleLen = edgeLength[`VTS_LEN_DOUBLE];
	wire withCorr = (shapeCode == `VTS_CODE_LUT_CORR);
	// Correction adds one extra state that lands exactly on the target
	wire [5:0] lastStep = withCorr ? stateCount + 6'h01 : stateCount;
	wire inCorr = (step_q > stateCount);
	wire [5:0] stepEff = inCorr ? stateCount : step_q;
	wire [13:0] progNum = {stepEff, 8'h00} - {8'h00, stepEff};
	wire [13:0] progDiv = progNum / {8'h00, stateCount};
	wire [7:0] progress = (stateCount == 6'h00) ? `VTS_AMP_FULL : progDiv[7:0];
	wire [7:0] shapedLevel;
	wire [7:0] swing = `VTS_AMP_FULL - residual;
	wire [16:0] deltaProd = swing * ({1'b0, shapedLevel} + 9'h001);
	wire [7:0] delta = deltaProd[15:8];

	// Shape function for the active edge
	vts_curve curve (
		.shapeCode(shapeCode),
		.styleSel(styleSel),
		.progress(progress),
		.supplyLevel(supply_q),
		.shapedLevel(shapedLevel)
	);

	// Two-flop synchronisers; supply is slow, so per-bit sync is safe enough
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			modSync1_q <= 1'b0;
			modSync2_q <= 1'b0;
			tickSync1_q <= 1'b0;
			tickSync2_q <= 1'b0;
			tickSync3_q <= 1'b0;
			supplySync1_q <= `VTS_AMP_FULL;
			supplySync2_q <= `VTS_AMP_FULL;
		end else begin
			modSync1_q <= modRequest;
			modSync2_q <= modSync1_q;
			tickSync1_q <= carrierTick;
			tickSync2_q <= tickSync1_q;
			tickSync3_q <= tickSync2_q;
			supplySync1_q <= amplifierSupplyVoltage;
			supplySync2_q <= supplySync1_q;
		end
	end

	// APB slave: one wait-free access phase, answer registered in setup
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else if (setupPhase) begin
			pready <= 1'b1;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
			// Read mux; reserved bits already held at zero
			case (regIdx)
				`VTS_IDX_SLOW_RESID: prdata[`VTS_BYTE] <= slowResidualLevel_q;
				`VTS_IDX_SLOW_TYPE: prdata[`VTS_BYTE] <= slowEdgeType_q;
				`VTS_IDX_SLOW_STYLE: prdata[`VTS_BYTE] <= slowEdgeStyle_q;
				`VTS_IDX_SLOW_LEN: prdata[`VTS_BYTE] <= slowEdgeLength_q;
				`VTS_IDX_FAST_RESID: prdata[`VTS_BYTE] <= fastResidualLevel_q;
				`VTS_IDX_FAST_TYPE: prdata[`VTS_BYTE] <= fastEdgeType_q;
				`VTS_IDX_FAST_STYLE: prdata[`VTS_BYTE] <= fastEdgeStyle_q;
				`VTS_IDX_FAST_LEN: prdata[`VTS_BYTE] <= fastEdgeLength_q;
				`VTS_IDX_CTRL: prdata[`VTS_BYTE] <= control_q;
				// Live status: amplitude, state, latched group, busy
				`VTS_IDX_STAT: prdata[15:0] <= {carrierAmplitude, state_q, 2'h0, group_q, edgeBusy};
				// Unmapped index answers with an error
				default: pslverr <= 1'b1;
			endcase
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Register writes take effect at the completing access edge
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			slowResidualLevel_q <= `VTS_RST_RESID;
			slowEdgeType_q <= `VTS_RST_TYPE;
			slowEdgeStyle_q <= `VTS_RST_STYLE;
			slowEdgeLength_q <= `VTS_RST_LEN;
			fastResidualLevel_q <= `VTS_RST_RESID;
			fastEdgeType_q <= `VTS_RST_TYPE;
			fastEdgeStyle_q <= `VTS_RST_STYLE;
			fastEdgeLength_q <= `VTS_RST_LEN;
			control_q <= `VTS_RST_CTRL;
		end else if (writeNow) begin
			// Reserved bits are dropped on write, so they read back as zero
			case (regIdx)
				`VTS_IDX_SLOW_RESID: slowResidualLevel_q <= wByte;
				`VTS_IDX_SLOW_TYPE: slowEdgeType_q <= wByte;
				`VTS_IDX_SLOW_STYLE: slowEdgeStyle_q <= wByte & `VTS_STYLE_MASK;
				`VTS_IDX_SLOW_LEN: slowEdgeLength_q <= wByte & `VTS_LEN_MASK;
				`VTS_IDX_FAST_RESID: fastResidualLevel_q <= wByte;
				`VTS_IDX_FAST_TYPE: fastEdgeType_q <= wByte;
				`VTS_IDX_FAST_STYLE: fastEdgeStyle_q <= wByte & `VTS_STYLE_MASK;
				`VTS_IDX_FAST_LEN: fastEdgeLength_q <= wByte & `VTS_LEN_MASK;
				`VTS_IDX_CTRL: control_q <= wByte & `VTS_CTRL_MASK;
				// Status and unmapped indices ignore writes
				default: control_q <= control_q;
			endcase
		end
	end

	// Next-state and amplitude logic of the edge sequencer
	always @* begin
		state_d = state_q;
		step_d = step_q;
		half_d = half_q;
		group_d = group_q;
		supply_d = supply_q;
		amp_d = `VTS_AMP_FULL;
		case (state_q)
			// Full carrier until a pause is requested
			ST_UNMOD: begin
				if (enable && modSync2_q) begin
					// Group and supply frozen for the whole pause
					group_d = control_q[`VTS_CTRL_FAST];
					supply_d = supplySync2_q;
					step_d = 6'h01;
					half_d = 1'b0;
					state_d = ST_FALL;
				end
			end
			// Falling edge: full level down toward residual
			ST_FALL: begin
				amp_d = inCorr ? residual : `VTS_AMP_FULL - delta;
				if (stateCount == 6'h00) begin
					state_d = ST_LOW;
				end else if (tickPulse) begin
					if (doubleLen && !half_q) begin
						half_d = 1'b1;
					end else begin
						half_d = 1'b0;
						if (step_q >= lastStep) begin
							state_d = ST_LOW;
						end else begin
							step_d = step_q + 6'h01;
						end
					end
				end
			end
			// Residual level held while the pause lasts
			ST_LOW: begin
				amp_d = residual;
				if (!modSync2_q) begin
					step_d = 6'h01;
					half_d = 1'b0;
					state_d = ST_RISE;
				end
			end
			// Rising edge; a new request waits until it completes
			ST_RISE: begin
				amp_d = inCorr ? `VTS_AMP_FULL : residual + delta;
				if (stateCount == 6'h00) begin
					state_d = ST_UNMOD;
				end else if (tickPulse) begin
					if (doubleLen && !half_q) begin
						half_d = 1'b1;
					end else begin
						half_d = 1'b0;
						if (step_q >= lastStep) begin
							state_d = ST_UNMOD;
						end else begin
							step_d = step_q + 6'h01;
						end
					end
				end
			end
			default: state_d = ST_UNMOD;
		endcase
		// Disabling drops straight back to full carrier
		if (!enable) begin
			state_d = ST_UNMOD;
			amp_d = `VTS_AMP_FULL;
		end
	end

	// Sequencer registers and registered outputs
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= ST_UNMOD;
			step_q <= 6'h01;
			half_q <= 1'b0;
			group_q <= 1'b0;
			supply_q <= `VTS_AMP_FULL;
			carrierAmplitude <= `VTS_AMP_FULL;
			edgeBusy <= 1'b0;
		end else begin
			state_q <= state_d;
			step_q <= step_d;
			half_q <= half_d;
			group_q <= group_d;
			supply_q <= supply_d;
			carrierAmplitude <= amp_d;
			edgeBusy <= (state_d == ST_FALL) | (state_d == ST_RISE);
		end
	end
endmodule

// ==== vts_shaper_properties.sv ====
// Bound checker for the edge shaper ports
`timescale 1ns/1ps
module vts_checker (
	input wire clock,
	input wire reset_n,
	input wire psel,
	input wire penable,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire modRequest,
	input wire [7:0] carrierAmplitude,
	input wire edgeBusy
);
	wire setup = psel && !penable; // Setup phase of a transfer
	wire [9:0] idx = paddr[11:2]; // Word index
	// Both groups, control and status answer without error
	wire mapped = (idx >= 10'h04C && idx <= 10'h053) || idx == 10'h060 || idx == 10'h061;
	default clocking @(posedge clock);
	endclocking
	default disable iff (!reset_n);
	a_answer_after_setup: assert property (setup |=> pready) // Bus timing
		else $error("no answer after setup");
	a_quiet_without_setup: assert property (!setup |=> !pready) // Bus timing
		else $error("answer without setup");
	a_error_with_ready: assert property (pslverr |-> pready) // Bus timing
		else $error("error without ready");
	a_unmapped_error: assert property (setup && !mapped |=> pslverr) // Bus map
		else $error("unmapped access not refused");
	a_mapped_clean: assert property (setup && mapped |=> !pslverr) // Bus map
		else $error("mapped access refused");
	a_rdata_holds: assert property (!setup |=> $stable(prdata)) // Bus timing
		else $error("read data moved without setup");
	a_reset_full_carrier: assert property ($rose(reset_n) |-> carrierAmplitude == 8'hFF && !edgeBusy)
		else $error("carrier not full after reset");
	// Long quiet with no edge running must mean an unmodulated carrier
	a_idle_full_carrier: assert property ((!modRequest && !edgeBusy) [*8] |-> carrierAmplitude == 8'hFF)
		else $error("carrier not full while idle");
endmodule
bind vts_shaper vts_checker chk (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .modRequest(modRequest),
	.carrierAmplitude(carrierAmplitude), .edgeBusy(edgeBusy));

// ==== vts_rf_stage.sv ====
// Carrier stage model: gives carrier cycles and the supply code
`timescale 1ns/1ps
module vts_rf_stage (
	input wire clock,
	input wire edgeBusy,
	output reg carrierTick,
	output reg [7:0] amplifierSupplyVoltage
);
	integer gap = 4; // Low time; raise it to model a slow carrier
	initial begin
		carrierTick = 1'b0;
		amplifierSupplyVoltage = 8'hFF;
	end
	// One carrier cycle, long enough to pass the pin synchroniser
	task pulse;
		begin
			@(posedge clock);
			// Carrier cycles only reach the shaper while an edge runs
			if (edgeBusy === 1'b1)
				carrierTick <= 1'b1;
			repeat (2) @(posedge clock);
			carrierTick <= 1'b0;
			repeat (gap) @(posedge clock);
		end
	endtask
endmodule

// ==== vts_testbench.sv ====
// Self-checking bench for the transmit edge shaper
`timescale 1ns/1ps
`include "vts_defines.vh"
module testbench;
	reg clock = 1'b0;
	reg reset_n = 1'b0;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg [11:0] paddr = 12'h000;
	reg [31:0] pwdata = 32'h00000000;
	reg [3:0] pstrb = 4'hF;
	reg modRequest = 1'b0;
	wire [31:0] prdata;
	wire pready, pslverr, carrierTick, edgeBusy;
	wire [7:0] amplifierSupplyVoltage, carrierAmplitude;
	integer nErrors = 0;
	integer testsRun = 0;
	integer ticks; // Carrier cycles one edge took
	integer i;
	reg [31:0] rdV; // Last read data
	reg rdE; // Last error flag
	vts_shaper dut (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.modRequest(modRequest), .carrierTick(carrierTick), .amplifierSupplyVoltage(amplifierSupplyVoltage),
		.carrierAmplitude(carrierAmplitude), .edgeBusy(edgeBusy));
	vts_rf_stage rf (.clock(clock), .edgeBusy(edgeBusy), .carrierTick(carrierTick),
		.amplifierSupplyVoltage(amplifierSupplyVoltage));
	initial begin
		forever #20 clock = ~clock;
	end
	task check(input string what, input [31:0] seen, input [31:0] exp);
		begin
			testsRun = testsRun + 1;
			if (seen !== exp) begin
				nErrors = nErrors + 1;
				$display("wrong value %s expected %h seen %h", what, exp, seen);
			end
		end
	endtask
	// One APB transfer; only the watchdog ends a wait for pready
	task xfer(input w, input [9:0] idx, input [7:0] d, input [3:0] s);
		begin
			@(posedge clock);
			psel <= 1'b1;
			penable <= 1'b0;
			pwrite <= w;
			paddr <= {idx, 2'b00};
			pwdata <= {24'h000000, d};
			pstrb <= s;
			@(posedge clock);
			penable <= 1'b1;
			// Request stands until pready is seen high at a rising edge
			@(posedge clock);
			while (pready !== 1'b1)
				@(posedge clock);
			// Answer taken at that same edge, then the request is released
			rdV = prdata;
			rdE = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	// Moves the pause request, then counts carrier cycles until the edge ends
	task runEdge(input lvl);
		begin
			@(posedge clock);
			modRequest <= lvl;
			repeat (8) @(posedge clock);
			ticks = 0;
			while (edgeBusy === 1'b1 && ticks < 80) begin
				rf.pulse();
				ticks = ticks + 1;
			end
		end
	endtask
	// Fall to the slow residual 0x40 and rise back
	task edgeCase(input [7:0] typ, input [7:0] len, input integer fallN, input integer riseN, input lvl);
		begin
			xfer(1, `VTS_IDX_SLOW_TYPE, typ, 4'hF);
			xfer(1, `VTS_IDX_SLOW_LEN, len, 4'hF);
			runEdge(1'b1);
			check("fall cycles", ticks, fallN);
			if (lvl)
				check("low level", carrierAmplitude, 8'h40);
			runEdge(1'b0);
			check("rise cycles", ticks, riseN);
			check("full level", carrierAmplitude, `VTS_AMP_FULL);
		end
	endtask
	task testReset;
		begin
			for (i = 0; i < 8; i = i + 1) begin
				xfer(0, 10'h04C + i, 8'h00, 4'hF);
				check("reset value", rdV, i % 4 == 0 ? `VTS_RST_RESID : i % 4 == 1 ? `VTS_RST_TYPE :
					i % 4 == 2 ? `VTS_RST_STYLE : `VTS_RST_LEN);
			end
			xfer(0, `VTS_IDX_CTRL, 8'h00, 4'hF);
			check("control", rdV, `VTS_RST_CTRL);
			xfer(1, 10'h3FF, 8'h55, 4'hF);
			check("unmapped error", rdE, 1'b1);
		end
	endtask
	// Reserved bits read zero; a write without the low strobe is dropped
	task testMask;
		begin
			xfer(1, `VTS_IDX_SLOW_STYLE, 8'hFF, 4'hF);
			xfer(0, `VTS_IDX_SLOW_STYLE, 8'h00, 4'hF);
			check("style mask", rdV, 32'h00000077);
			xfer(1, `VTS_IDX_SLOW_LEN, 8'hFF, 4'hF);
			xfer(0, `VTS_IDX_SLOW_LEN, 8'h00, 4'hF);
			check("length mask", rdV, 32'h0000009F);
			xfer(1, `VTS_IDX_SLOW_STYLE, 8'h00, 4'hF);
			xfer(1, `VTS_IDX_SLOW_TYPE, 8'h22, 4'hE);
			xfer(0, `VTS_IDX_SLOW_TYPE, 8'h00, 4'hF);
			check("strobe drop", rdV, `VTS_RST_TYPE);
		end
	endtask
	task testCodes;
		begin
			@(posedge clock);
			rf.amplifierSupplyVoltage <= 8'h80;
			xfer(1, `VTS_IDX_SLOW_RESID, 8'h40, 4'hF);
			edgeCase(8'h11, 8'h02, 2, 2, 1);
			edgeCase(8'h21, 8'h02, 2, 2, 1);
			edgeCase(8'h31, 8'h02, 2, 2, 1);
			edgeCase(8'h41, 8'h02, 2, 2, 1);
			edgeCase(8'h51, 8'h02, 3, 2, 1);
			edgeCase(8'h61, 8'h02, 2, 2, 1);
			edgeCase(8'h15, 8'h02, 2, 3, 1);
			edgeCase(8'h11, 8'h82, 4, 4, 1);
			edgeCase(8'h11, 8'h00, 0, 0, 1);
			edgeCase(8'h11, 8'h1F, 31, 31, 1);
		end
	endtask
	// Fast group carries its own level and length
	task testRate;
		begin
			xfer(1, `VTS_IDX_FAST_RESID, 8'h00, 4'hF);
			xfer(1, `VTS_IDX_FAST_LEN, 8'h01, 4'hF);
			xfer(1, `VTS_IDX_CTRL, 8'h03, 4'hF);
			runEdge(1'b1);
			check("fast cycles", ticks, 1);
			check("zero carrier", carrierAmplitude, `VTS_AMP_ZERO);
			runEdge(1'b0);
			xfer(0, `VTS_IDX_SLOW_RESID, 8'h00, 4'hF);
			check("slow untouched", rdV, 32'h00000040);
		end
	endtask
	task completeRun;
		begin
			if (nErrors == 0 && testsRun > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	initial begin
		repeat (10) @(posedge clock);
		reset_n <= 1'b1;
		testReset;
		testMask;
		testCodes;
		testRate;
		completeRun;
	end
	// Watchdog at 10000 cycles, about ten times what the run needs
	initial begin
		#400000;
		nErrors = nErrors + 1;
		completeRun;
	end
endmodule
